/* File: bst_pkg.sv */
// constants, opcodes and types of the boundary-scan test and programming port
package bst_pkg;
  localparam int IR_W = 10;
  localparam int ID_W = 32;
  localparam int ISP_W = 16;
  localparam int BSR_LEN_240 = 240;
  localparam int BSR_LEN_480 = 480;
  localparam int BSR_LEN_636 = 636;
  localparam int BSR_LEN_816 = 816;
  localparam int BSR_LEN = BSR_LEN_480;
  // three cells per pin: input, output, output enable
  localparam int CELLS_PER_PIN = 3;
  localparam int NPINS = BSR_LEN / CELLS_PER_PIN;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;

  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] OP_EXTEST = 10'h00f;
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;
  localparam logic [IR_W-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_W-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] OP_HIGHZ = 10'h00b;
  localparam logic [IR_W-1:0] OP_CLAMP = 10'h00a;
  localparam logic [IR_W-1:0] OP_USER_A = 10'h00c;
  localparam logic [IR_W-1:0] OP_USER_B = 10'h00e;
  localparam logic [IR_W-1:0] OP_ISP_ENABLE = 10'h2c0;
  localparam logic [IR_W-1:0] OP_ISP_DISABLE = 10'h2c1;
  localparam logic [IR_W-1:0] OP_ISP_ERASE = 10'h2c2;
  localparam logic [IR_W-1:0] OP_ISP_PROGRAM = 10'h2c3;
  localparam logic [IR_W-1:0] OP_ISP_ADDRESS = 10'h2c4;
  localparam logic [IR_W-1:0] OP_ISP_DATA = 10'h2c5;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;

  // identity fields: values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  localparam logic [ID_W-1:0] USERCODE_RESET = 32'hffffffff;

  localparam longint CLK_HZ = 64'd20000000;
  localparam longint ERASE_TIME_MS = 64'd500;
  localparam longint PROGRAM_TIME_US = 64'd75;
  localparam longint ERASE_CYCLES = (ERASE_TIME_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam longint PROGRAM_CYCLES = (PROGRAM_TIME_US * CLK_HZ + 64'd999999) / 64'd1000000;
  localparam int CNT_W = 24;

  typedef enum logic [3:0] {
    ST_EXIT2_DR = 4'h0, ST_EXIT1_DR = 4'h1, ST_SHIFT_DR = 4'h2, ST_PAUSE_DR = 4'h3,
    ST_SEL_IR = 4'h4, ST_UPDATE_DR = 4'h5, ST_CAPTURE_DR = 4'h6, ST_SEL_DR = 4'h7,
    ST_EXIT2_IR = 4'h8, ST_EXIT1_IR = 4'h9, ST_SHIFT_IR = 4'ha, ST_PAUSE_IR = 4'hb,
    ST_IDLE = 4'hc, ST_UPDATE_IR = 4'hd, ST_CAPTURE_IR = 4'he, ST_RESET = 4'hf
  } bst_tap_e;
endpackage

/* File: bst_tap_isp.sv */
// boundary-scan test access port with user chains and programming pulse timer
`timescale 1ns/1ps
`default_nettype none

module bst_tap_isp
  import bst_pkg::*;
#(
  parameter int unsigned ERASE_WAIT = 32'(ERASE_CYCLES)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [NPINS-1:0] pad_in,
  output logic [NPINS-1:0] pad_out,
  output logic [NPINS-1:0] pad_oe_n,
  output logic pad_keeper_en,
  input wire logic [NPINS-1:0] core_out,
  input wire logic [NPINS-1:0] core_oe,
  output logic [NPINS-1:0] core_in,
  output logic user_tck,
  output logic user_tdi,
  output logic user_chain_a_select,
  output logic user_chain_b_select,
  output logic user_capture,
  output logic user_shift,
  output logic user_update,
  input wire logic user_tdo,
  output logic isp_active,
  output logic flash_erase_pulse,
  output logic flash_prog_pulse,
  output logic [ISP_W-1:0] flash_addr,
  output logic [ISP_W-1:0] flash_wdata
);

  // reset release synchronised per domain; assertion stays asynchronous
  logic trst_q1, trst_q2, crst_q1, crst_q2;
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      trst_q1 <= 1'b0;
      trst_q2 <= 1'b0;
    end else begin
      trst_q1 <= 1'b1;
      trst_q2 <= trst_q1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crst_q1 <= 1'b0;
      crst_q2 <= 1'b0;
    end else begin
      crst_q1 <= 1'b1;
      crst_q2 <= crst_q1;
    end
  end
  wire trst_n = trst_q2;
  wire crst_n = crst_q2;

  // tap state machine
  bst_tap_e state_q, state_d;
  always_comb begin
    case (state_q)
      ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET;
    endcase
  end
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) state_q <= ST_RESET;
    else state_q <= state_d;
  end

  wire in_reset = (state_q == ST_RESET);
  wire cap_dr = (state_q == ST_CAPTURE_DR);
  wire sh_dr = (state_q == ST_SHIFT_DR);
  wire up_dr = (state_q == ST_UPDATE_DR);
  wire cap_ir = (state_q == ST_CAPTURE_IR);
  wire sh_ir = (state_q == ST_SHIFT_IR);
  wire up_ir = (state_q == ST_UPDATE_IR);

  // instruction register
  logic [IR_W-1:0] ir_sh_q, ir_q;
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh_q <= IR_CAPTURE;
      ir_q <= OP_IDCODE;
    end else begin
      if (cap_ir) ir_sh_q <= IR_CAPTURE;
      else if (sh_ir) ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
      if (in_reset) ir_q <= OP_IDCODE;
      else if (up_ir) ir_q <= ir_sh_q;
    end
  end

  // instruction decode; anything unknown falls back to bypass
  wire op_sample = (ir_q == OP_SAMPLE);
  wire op_extest = (ir_q == OP_EXTEST);
  wire op_highz = (ir_q == OP_HIGHZ);
  wire op_clamp = (ir_q == OP_CLAMP);
  wire sel_bsr = op_sample | op_extest;
  wire sel_id = (ir_q == OP_IDCODE);
  wire sel_uc = (ir_q == OP_USERCODE);
  wire sel_ua = (ir_q == OP_USER_A);
  wire sel_ub = (ir_q == OP_USER_B);
  wire sel_addr = (ir_q == OP_ISP_ADDRESS);
  wire sel_data = (ir_q == OP_ISP_DATA);
  wire sel_byp = ~(sel_bsr | sel_id | sel_uc | sel_ua | sel_ub | sel_addr | sel_data);

  // pin synchroniser for capture, tck side
  // core drive values live on clk, so they are retimed like the pins
  logic [NPINS-1:0] pin_t_q1, pin_t_q2, cout_t_q1, cout_t_q2, coe_t_q1, coe_t_q2;
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      pin_t_q1 <= '0;
      pin_t_q2 <= '0;
      cout_t_q1 <= '0;
      cout_t_q2 <= '0;
      coe_t_q1 <= '0;
      coe_t_q2 <= '0;
    end else begin
      pin_t_q1 <= pad_in;
      pin_t_q2 <= pin_t_q1;
      cout_t_q1 <= core_out;
      cout_t_q2 <= cout_t_q1;
      coe_t_q1 <= core_oe;
      coe_t_q2 <= coe_t_q1;
    end
  end

  // boundary register: capture image, shift stage and update latch
  logic [BSR_LEN-1:0] bsr_cap, bsr_sh_q, bsr_up_q;
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_cell
      assign bsr_cap[CELLS_PER_PIN*gi+CELL_IN] = pin_t_q2[gi];
      assign bsr_cap[CELLS_PER_PIN*gi+CELL_OUT] = cout_t_q2[gi];
      assign bsr_cap[CELLS_PER_PIN*gi+CELL_OE] = coe_t_q2[gi];
    end
  endgenerate
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bsr_sh_q <= '0;
      bsr_up_q <= '0;
    end else begin
      if (sel_bsr && cap_dr) bsr_sh_q <= bsr_cap;
      else if (sel_bsr && sh_dr) bsr_sh_q <= {tdi, bsr_sh_q[BSR_LEN-1:1]};
      if (sel_bsr && up_dr) bsr_up_q <= bsr_sh_q;
    end
  end

  // bypass, identity, usercode and programming registers
  logic byp_q;
  logic [ID_W-1:0] id_sh_q, uc_sh_q;
  logic [ISP_W-1:0] addr_sh_q, data_sh_q, addr_q, data_q;
  logic isp_q;
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      byp_q <= 1'b0;
      id_sh_q <= ID_VALUE;
      uc_sh_q <= USERCODE_RESET;
    end else begin
      if (sel_byp && cap_dr) byp_q <= 1'b0;
      else if (sel_byp && sh_dr) byp_q <= tdi;
      if (sel_id && cap_dr) id_sh_q <= ID_VALUE;
      else if (sel_id && sh_dr) id_sh_q <= {tdi, id_sh_q[ID_W-1:1]};
      if (sel_uc && cap_dr) uc_sh_q <= USERCODE_RESET;
      else if (sel_uc && sh_dr) uc_sh_q <= {tdi, uc_sh_q[ID_W-1:1]};
    end
  end
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      addr_sh_q <= '0;
      data_sh_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      isp_q <= 1'b0;
    end else begin
      if (sel_addr && sh_dr) addr_sh_q <= {tdi, addr_sh_q[ISP_W-1:1]};
      if (sel_data && sh_dr) data_sh_q <= {tdi, data_sh_q[ISP_W-1:1]};
      if (sel_addr && up_dr) addr_q <= addr_sh_q;
      if (sel_data && up_dr) data_q <= data_sh_q;
      // programming mode lives until disable or test reset
      if (in_reset || (up_ir && ir_sh_q == OP_ISP_DISABLE)) isp_q <= 1'b0;
      else if (up_ir && ir_sh_q == OP_ISP_ENABLE) isp_q <= 1'b1;
    end
  end
  assign isp_active = isp_q;

  // pin control: test modes override core, programming floats pins
  wire test_drive = op_extest | op_clamp;
  wire float_all = op_highz | isp_q;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      assign pad_out[gi] = test_drive ? bsr_up_q[CELLS_PER_PIN*gi+CELL_OUT] : core_out[gi];
      assign pad_oe_n[gi] = float_all ? 1'b1 :
                            test_drive ? ~bsr_up_q[CELLS_PER_PIN*gi+CELL_OE] : ~core_oe[gi];
    end
  endgenerate
  // keepers are never switched off by the test instructions
  assign pad_keeper_en = 1'b1;

  // core-side view of pins, clk domain
  logic [NPINS-1:0] pin_c_q1, pin_c_q2;
  always_ff @(posedge clk or negedge crst_n) begin
    if (!crst_n) begin
      pin_c_q1 <= '0;
      pin_c_q2 <= '0;
    end else begin
      pin_c_q1 <= pad_in;
      pin_c_q2 <= pin_c_q1;
    end
  end
  assign core_in = pin_c_q2;

  // user chains run directly on the test clock
  wire sel_user = sel_ua | sel_ub;
  assign user_tck = tck;
  assign user_tdi = tdi;
  assign user_chain_a_select = sel_ua;
  assign user_chain_b_select = sel_ub;
  assign user_capture = sel_user & cap_dr;
  assign user_shift = sel_user & sh_dr;
  assign user_update = sel_user & up_dr;

  // serial output mux, launched on the falling edge
  wire dr_bit = sel_bsr ? bsr_sh_q[0] :
                sel_id ? id_sh_q[0] :
                sel_uc ? uc_sh_q[0] :
                sel_user ? user_tdo :
                sel_addr ? addr_sh_q[0] :
                sel_data ? data_sh_q[0] : byp_q;
  wire tdo_mux = sh_ir ? ir_sh_q[0] : dr_bit;
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo <= tdo_mux;
      tdo_oe_n <= ~(sh_ir | sh_dr);
    end
  end

  // pulse request: levels held while the tap waits in idle
  wire req_erase_t = isp_q & (state_q == ST_IDLE) & (ir_q == OP_ISP_ERASE);
  wire req_prog_t = isp_q & (state_q == ST_IDLE) & (ir_q == OP_ISP_PROGRAM);
  logic [1:0] req_q1, req_q2;
  logic [CNT_W-1:0] cnt_q;
  logic done_q;
  logic ep_q, pp_q;
  logic [ISP_W-1:0] faddr_q, fdata_q;
  wire req_e = req_q2[1];
  wire req_p = req_q2[0];
  wire [CNT_W-1:0] target = req_e ? CNT_W'(ERASE_WAIT - 1) : CNT_W'(PROGRAM_CYCLES - 1);
  wire hit = (req_e | req_p) & ~done_q & (cnt_q == target);
  always_ff @(posedge clk or negedge crst_n) begin
    if (!crst_n) begin
      req_q1 <= 2'h0;
      req_q2 <= 2'h0;
    end else begin
      req_q1 <= {req_erase_t, req_prog_t};
      req_q2 <= req_q1;
    end
  end
  // leaving idle early aborts the pulse; address and data are steady meanwhile
  always_ff @(posedge clk or negedge crst_n) begin
    if (!crst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      ep_q <= 1'b0;
      pp_q <= 1'b0;
      faddr_q <= '0;
      fdata_q <= '0;
    end else begin
      if (!(req_e | req_p)) cnt_q <= '0;
      else if (!done_q && !hit) cnt_q <= cnt_q + 24'h000001;
      done_q <= (req_e | req_p) & (done_q | hit);
      ep_q <= hit & req_e;
      pp_q <= hit & req_p;
      if (hit) faddr_q <= addr_q;
      if (hit) fdata_q <= data_q;
    end
  end
  assign flash_erase_pulse = ep_q;
  assign flash_prog_pulse = pp_q;
  assign flash_addr = faddr_q;
  assign flash_wdata = fdata_q;

  AST_TLR_FIVE: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] |=> state_q == ST_RESET) else $error("five high tms did not reset tap");
  AST_IR_RESET: assert property (@(posedge tck) disable iff (!trst_n)
    state_q == ST_RESET |=> ir_q == OP_IDCODE) else $error("reset did not load idcode");
  AST_IR_LOAD: assert property (@(posedge tck) disable iff (!trst_n)
    up_ir |=> ir_q == $past(ir_sh_q)) else $error("instruction not loaded on update");
  AST_BYPASS_PATH: assert property (@(posedge tck) disable iff (!trst_n)
    (sel_byp && sh_dr) ##1 (sel_byp && sh_dr) |-> dr_bit == $past(tdi))
    else $error("bypass path not one stage");
  AST_HIGHZ: assert property (@(posedge tck) disable iff (!trst_n)
    op_highz |-> &pad_oe_n) else $error("pin driven under highz");
  AST_CLAMP: assert property (@(posedge tck) disable iff (!trst_n)
    op_clamp |-> pad_out[0] == bsr_up_q[CELL_OUT] && sel_byp)
    else $error("clamp does not hold boundary value");
  AST_ID_CAPTURE: assert property (@(posedge tck) disable iff (!trst_n)
    (sel_id && cap_dr) |=> id_sh_q == ID_VALUE && id_sh_q[0])
    else $error("identity capture wrong");
  AST_UC_CAPTURE: assert property (@(posedge tck) disable iff (!trst_n)
    (sel_uc && cap_dr) |=> uc_sh_q == USERCODE_RESET) else $error("usercode capture wrong");
  AST_USER_STROBE: assert property (@(posedge tck) disable iff (!trst_n)
    sel_user |-> (user_shift == sh_dr) && (dr_bit == user_tdo))
    else $error("user chain strobe or data wrong");
  AST_PROG_PULSE: assert property (@(posedge clk) disable iff (!crst_n)
    flash_prog_pulse |-> $past(cnt_q) == CNT_W'(PROGRAM_CYCLES - 1) ##1 !flash_prog_pulse)
    else $error("program pulse timing wrong");

endmodule

`default_nettype wire

/* File: bst_jtag_host.sv */
// far-side scan controller model for the test access port
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_host
  import bst_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic tick(input logic m, input logic b, input logic sh, output logic q);
    tms = m;
    // unused data line toggles so a stale bit never passes for data
    tdi = sh ? b : ~tdi;
    #62.5;
    q = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  task automatic idle(input int n);
    logic q;
    repeat (n) tick(1'b0, 1'b0, 1'b0, q);
  endtask
  // five ones reach test-logic reset from any state, then park in idle
  task automatic reset_tap();
    logic q;
    repeat (5) tick(1'b1, 1'b0, 1'b0, q);
    tick(1'b0, 1'b0, 1'b0, q);
  endtask
  task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] din,
                      output logic [BSR_LEN-1:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, 1'b0, q);
    tick(1'b0, 1'b0, 1'b0, q);
    tick(1'b0, 1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], 1'b1, q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, 1'b0, q);
    tick(1'b0, 1'b0, 1'b0, q);
  endtask
endmodule
`default_nettype wire

/* File: test_boundary_scan_tap_isp_port.sv */
// self-checking bench for the boundary-scan test and programming port
`timescale 1ns/1ps
`default_nettype none
module test_boundary_scan_tap_isp_port;
  import bst_pkg::*;
  localparam logic [NPINS-1:0] PAT_A = {5{32'h96c35a0f}};
  localparam logic [NPINS-1:0] PAT_B = {5{32'h3c0ff0a5}};
  localparam logic [NPINS-1:0] PAT_C = {5{32'h5a3cc396}};
  logic clk, resetn, tck, tms, tdi, tdo, tdo_oe_n, pad_keeper_en;
  logic [NPINS-1:0] pad_in, pad_out, pad_oe_n, core_out, core_oe, core_in;
  logic user_tck, user_tdi, user_a, user_b, user_capture, user_shift, user_update, user_q;
  logic isp_active, flash_erase_pulse, flash_prog_pulse;
  logic [ISP_W-1:0] flash_addr, flash_wdata;
  logic [BSR_LEN-1:0] cap, d;
  int err_total = 0;
  int num_checks = 0;
  int prog_cnt = 0;
  int erase_cnt = 0;
  int oe_low = 0;
  int upd_cnt = 0;

  bst_tap_isp #(.ERASE_WAIT(50)) bst_tap_isp_inst (
    .clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_keeper_en(pad_keeper_en), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .user_tck(user_tck), .user_tdi(user_tdi),
    .user_chain_a_select(user_a), .user_chain_b_select(user_b),
    .user_capture(user_capture), .user_shift(user_shift), .user_update(user_update),
    .user_tdo(user_q), .isp_active(isp_active), .flash_erase_pulse(flash_erase_pulse),
    .flash_prog_pulse(flash_prog_pulse), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata));
  bst_jtag_host bst_jtag_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // one-bit user chain that captures a one
  always @(posedge user_tck or negedge resetn)
    if (!resetn) user_q <= 1'b0;
    else if (user_capture) user_q <= 1'b1;
    else if (user_shift) user_q <= user_tdi;
  // a pulse held two cycles counts twice
  always @(posedge clk) begin
    if (flash_prog_pulse === 1'b1) prog_cnt++;
    if (flash_erase_pulse === 1'b1) erase_cnt++;
  end
  // serial output enable and user update strobe seen at each test clock rise
  always @(posedge tck) begin
    if (tdo_oe_n === 1'b0) oe_low++;
    if (user_update === 1'b1) upd_cnt++;
  end

  task automatic chk_reg(input string what, input logic [ID_W:0] exp, input logic [ID_W:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pins(input string what, input logic [NPINS-1:0] exp,
                          input logic [NPINS-1:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  function automatic logic [NPINS-1:0] in_cells(input logic [BSR_LEN-1:0] v);
    for (int i = 0; i < NPINS; i++) in_cells[i] = v[CELLS_PER_PIN*i+CELL_IN];
  endfunction
  task automatic ir_load(input logic [IR_W-1:0] op);
    bst_jtag_host_inst.scan(1'b1, IR_W, BSR_LEN'(op), cap);
  endtask
  task automatic dr(input int n, input logic [BSR_LEN-1:0] din);
    bst_jtag_host_inst.scan(1'b0, n, din, d);
  endtask
  task automatic one_bit(input string what, input logic [IR_W-1:0] op, input logic c);
    ir_load(op);
    dr(9, BSR_LEN'(9'h0b5));
    chk_reg(what, 33'({8'hb5, c}), 33'(d[8:0]));
  endtask

  task automatic t_id();
    int base;
    bst_jtag_host_inst.reset_tap();
    chk_bit("tdo_oe_n idle", 1'b1, tdo_oe_n);
    base = oe_low;
    dr(ID_W + 1, BSR_LEN'(1'b1));
    chk_reg("idcode", {1'b1, ID_VALUE}, d[ID_W:0]);
    chk_reg("tdo enable cycles", 33'(ID_W + 1), 33'(oe_low - base));
    ir_load(OP_IDCODE);
    chk_reg("ir capture", 33'(IR_CAPTURE), 33'(cap[IR_W-1:0]));
  endtask
  task automatic t_bypass();
    one_bit("bypass", OP_BYPASS, 1'b0);
    chk_pins("bypass pad_out", core_out, pad_out);
    chk_pins("bypass pad_oe_n", ~core_oe, pad_oe_n);
    chk_pins("core_in", pad_in, core_in);
    @(negedge clk) core_out = ~PAT_B;
    core_oe = ~PAT_C;
    @(posedge clk);
    chk_pins("bypass pad_out follow", ~PAT_B, pad_out);
    chk_pins("bypass pad_oe_n follow", PAT_C, pad_oe_n);
    one_bit("highz", OP_HIGHZ, 1'b0);
    chk_pins("highz pad_oe_n", {NPINS{1'b1}}, pad_oe_n);
    chk_bit("highz keeper", 1'b1, pad_keeper_en);
    one_bit("clamp", OP_CLAMP, 1'b0);
  endtask
  task automatic t_usercode();
    ir_load(OP_USERCODE);
    dr(ID_W + 1, BSR_LEN'(1'b1));
    chk_reg("usercode", {1'b1, USERCODE_RESET}, d[ID_W:0]);
  endtask
  task automatic t_user();
    int base;
    base = upd_cnt;
    one_bit("user a", OP_USER_A, 1'b1);
    chk_bit("select a", 1'b1, user_a);
    chk_bit("select b off", 1'b0, user_b);
    one_bit("user b", OP_USER_B, 1'b1);
    chk_bit("select b", 1'b1, user_b);
    chk_bit("select a off", 1'b0, user_a);
    chk_reg("user updates", 33'h2, 33'(upd_cnt - base));
  endtask
  task automatic t_boundary();
    logic [BSR_LEN-1:0] pre;
    pre = '0;
    for (int i = 0; i < NPINS; i++) begin
      pre[CELLS_PER_PIN*i+CELL_OUT] = PAT_B[i];
      pre[CELLS_PER_PIN*i+CELL_OE] = PAT_C[i];
    end
    ir_load(OP_SAMPLE);
    dr(BSR_LEN, pre);
    chk_pins("sample inputs", PAT_A, in_cells(d));
    chk_pins("sample pad_out", core_out, pad_out);
    ir_load(OP_EXTEST);
    chk_pins("extest pad_out", PAT_B, pad_out);
    chk_pins("extest pad_oe_n", ~PAT_C, pad_oe_n);
    @(negedge clk) pad_in = ~PAT_A;
    dr(BSR_LEN, pre);
    chk_pins("extest inputs", ~PAT_A, in_cells(d));
    chk_bit("extest keeper", 1'b1, pad_keeper_en);
    ir_load(OP_CLAMP);
    chk_pins("clamp pad_out", PAT_B, pad_out);
    chk_pins("clamp pad_oe_n", ~PAT_C, pad_oe_n);
  endtask
  task automatic t_isp();
    ir_load(OP_ISP_ENABLE);
    bst_jtag_host_inst.idle(2);
    chk_bit("isp_active", 1'b1, isp_active);
    chk_pins("isp pad_oe_n", {NPINS{1'b1}}, pad_oe_n);
    ir_load(OP_IDCODE);
    dr(ID_W, '0);
    chk_reg("isp idcode", {1'b0, ID_VALUE}, d[ID_W:0]);
    ir_load(OP_ISP_ADDRESS);
    dr(ISP_W, BSR_LEN'(16'h1c3a));
    ir_load(OP_ISP_DATA);
    dr(ISP_W, BSR_LEN'(16'h5ae7));
    ir_load(OP_ISP_PROGRAM);
    bst_jtag_host_inst.idle(580);
    chk_reg("prog early", 33'h0, 33'(prog_cnt));
    bst_jtag_host_inst.idle(60);
    chk_reg("prog pulses", 33'h1, 33'(prog_cnt));
    chk_reg("flash_addr", 33'h1c3a, 33'(flash_addr));
    chk_reg("flash_wdata", 33'h5ae7, 33'(flash_wdata));
    ir_load(OP_ISP_ERASE);
    bst_jtag_host_inst.idle(18);
    chk_reg("erase early", 33'h0, 33'(erase_cnt));
    bst_jtag_host_inst.idle(30);
    chk_reg("erase pulses", 33'h1, 33'(erase_cnt));
    // two short stays add up past the wait, so a count kept across stays would fire
    ir_load(OP_ISP_ERASE);
    bst_jtag_host_inst.idle(14);
    ir_load(OP_ISP_ERASE);
    bst_jtag_host_inst.idle(14);
    ir_load(OP_ISP_ADDRESS);
    bst_jtag_host_inst.idle(40);
    chk_reg("erase abort", 33'h1, 33'(erase_cnt));
    ir_load(OP_ISP_DISABLE);
    bst_jtag_host_inst.idle(2);
    chk_bit("isp off", 1'b0, isp_active);
  endtask

  task automatic t_reset();
    ir_load(OP_ISP_ENABLE);
    chk_bit("isp before reset", 1'b1, isp_active);
    @(negedge clk) resetn = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit("isp in reset", 1'b0, isp_active);
    chk_pins("reset pad_oe_n", ~core_oe, pad_oe_n);
    chk_reg("reset flash_addr", 33'h0, 33'(flash_addr));
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    // the first test clock edges only release the tck-side reset synchroniser
    t_id();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    pad_in = PAT_A;
    core_out = PAT_B;
    core_oe = PAT_C;
    repeat (8) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_id();
    t_bypass();
    t_usercode();
    t_user();
    t_boundary();
    t_isp();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
